// >>> core/tec_timer_event_cfg.sv
// tec_timer_event_cfg: timer capture/invert, debug, event and irq enable control
// Contract
// - channel capture select bit picks capture/compare
// - invert bit inverts that channel waveform pin
// - debug halt stops timer unless run bit
// - run bit survives software reset
// - channel event out on match/capture when enabled
// - wrap event out on overflow when enabled
// - incoming events accepted only while enabled
// - polarity bit inverts incoming event source
// - action field: off, retrigger, count, start
// - action five: period ch0, width ch1
// - action six: period ch1, width ch0
// - clear view one disables channel irq
// - clear view one disables sync irq
// - set and clear views share enables
// - clear view one disables error irq
// - clear view one disables wrap irq
// - capture onto set channel flag raises error
`timescale 1ns/1ps
`default_nettype none

module tec_timer_event_cfg (
   // clock and reset
   input  wire  logic          clk_in,
   input  wire  logic          nrst_in,
   // avalon-mm slave
   input  wire  logic [7:0]    avs_address_in,
   input  wire  logic          avs_read_in,
   input  wire  logic          avs_write_in,
   input  wire  logic [31:0]   avs_writedata_in,
   input  wire  logic [3:0]    avs_byteenable_in,
   output logic       [31:0]   avs_readdata_out,
   output logic                avs_waitrequest_out,
   // counter core side, same clock
   input  wire  logic          soft_reset_in,
   input  wire  logic          debug_halted_in,
   input  wire  logic [1:0]    chan_match_in,
   input  wire  logic          wrap_in,
   input  wire  logic          sync_done_in,
   input  wire  logic [1:0]    wave_raw_in,
   // asynchronous incoming event
   input  wire  logic          event_in,
   // outputs to counter core and pins
   output logic [1:0]          channel_capture_select_out,
   output logic                timer_halt_out,
   output tec_pkg::tec_act_s   action_out,
   output logic [1:0]          waveform_output_pin_out,
   output logic [1:0]          channel_event_out,
   output logic                wrap_event_out,
   output logic                irq_out
);

   // ==========================================================
   // helpers
   // merge write data into a register through byte lanes and mask
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [15:0] wd,
                                           input logic [1:0]  be,
                                           input logic [15:0] mask);
      logic [15:0] lanes;
      lanes = {{8{be[1]}}, {8{be[0]}}} & mask;
      merge16 = (old & ~lanes) | (wd & lanes);
   endfunction : merge16

   // ==========================================================
   // registers
   // flags sit at their own index; software writes one to clear a flag
   logic [7:0]   capinv_r;        // capture select / inversion
   logic [7:0]   dbg_r;           // debug run bit
   logic [15:0]  ev_r;            // event control
   logic [7:0]   irq_en_r;        // shared enable state
   logic [7:0]   flags_r;         // sticky flags
   logic         wait_r;          // waitrequest
   logic [31:0]  rdata_r;         // read data
   logic [2:0]   ev_sync_r;       // event synchroniser chain
   logic         ev_lvl_r;        // agreed event level
   logic         ev_cond_prev_r;  // last conditioned level
   logic [1:0]   capsel_r;        // registered capture select out
   logic         halt_r;          // registered halt out
   tec_pkg::tec_act_s act_r;      // registered action strobes
   logic [1:0]   wave_r;          // registered waveform pins
   logic [1:0]   chev_r;          // channel event out
   logic         wrapev_r;        // wrap event out
   logic         irq_r;           // interrupt out

   // ==========================================================
   // bus decode
   // commit marks the edge at which the master sees waitrequest low
   wire  logic [5:0] idx        = avs_address_in[7:2];        // register index
   wire  logic       req        = avs_read_in | avs_write_in; // any request
   wire  logic       commit     = req & ~wait_r;              // second edge of access
   wire  logic       wr_go      = avs_write_in & commit;      // write takes effect
   wire  logic       wr_capinv  = wr_go & (idx == tec_pkg::IDX_CAPINV);
   wire  logic       wr_dbg     = wr_go & (idx == tec_pkg::IDX_DBG);
   wire  logic       wr_ev      = wr_go & (idx == tec_pkg::IDX_EVCFG);
   wire  logic       wr_clr     = wr_go & (idx == tec_pkg::IDX_IRQCLR);
   wire  logic       wr_set     = wr_go & (idx == tec_pkg::IDX_IRQSET);
   wire  logic       wr_flg     = wr_go & (idx == tec_pkg::IDX_FLAGS);
   wire  logic [7:0] wd0        = avs_byteenable_in[0] ? avs_writedata_in[7:0] : 8'h00;

   // read mux; unmapped indices and reserved bits read zero
   // read data is taken on the first edge, before a write of the same access lands
   logic [31:0] rd_mux;
   always_comb begin
      unique case (idx)
         tec_pkg::IDX_CAPINV: rd_mux = {24'h000000, capinv_r};
         tec_pkg::IDX_DBG:    rd_mux = {24'h000000, dbg_r};
         tec_pkg::IDX_EVCFG:  rd_mux = {16'h0000, ev_r};
         tec_pkg::IDX_IRQCLR: rd_mux = {24'h000000, irq_en_r};
         tec_pkg::IDX_IRQSET: rd_mux = {24'h000000, irq_en_r};
         tec_pkg::IDX_FLAGS:  rd_mux = {24'h000000, flags_r};
         default:             rd_mux = 32'h00000000;
      endcase
   end

   // ==========================================================
   // field views
   // reserved positions never reach a flop, so they always read zero
   wire  logic [1:0] capsel   = capinv_r[tec_pkg::CAPSEL_LSB +: 2];
   wire  logic [1:0] inv      = capinv_r[tec_pkg::INV_LSB +: 2];
   wire  logic       run_dbg  = dbg_r[0];
   wire  logic [1:0] ch_eo    = ev_r[tec_pkg::EV_CHEO +: 2];
   wire  logic       wrap_eo  = ev_r[tec_pkg::EV_WRAPEO];
   wire  logic       in_en    = ev_r[tec_pkg::EV_INEN];
   wire  logic       in_pol   = ev_r[tec_pkg::EV_INPOL];
   wire  logic [2:0] act      = ev_r[2:0];

   // ==========================================================
   // incoming event conditioning
   // polarity applied, then gated by enable; edges are the events
   // limitation: flipping polarity or enable while the level stands makes
   // an edge of its own, so reprogram with the event source idle
   wire  logic ev_cond  = (ev_lvl_r ^ in_pol) & in_en;
   wire  logic ev_rise  = ev_cond & ~ev_cond_prev_r;    // event / period edge
   wire  logic ev_fall  = ~ev_cond & ev_cond_prev_r;    // end of pulse width
   wire  logic perwid   = (act == tec_pkg::ACT_PERWID);
   wire  logic widper   = (act == tec_pkg::ACT_WIDPER);

   // action decode; codes four and seven fall through to nothing
   // one code is live at a time, so at most one kind of strobe per edge
   tec_pkg::tec_act_s act_nxt;
   always_comb begin
      act_nxt           = '0;
      act_nxt.retrigger = ev_rise & (act == tec_pkg::ACT_RETRIG);
      act_nxt.count     = ev_rise & (act == tec_pkg::ACT_COUNT);
      act_nxt.start     = ev_rise & (act == tec_pkg::ACT_START);
      act_nxt.cap_per   = {ev_rise & widper, ev_rise & perwid};
      act_nxt.cap_wid   = {ev_fall & perwid, ev_fall & widper};
   end

   // ==========================================================
   // flags: a capture landing on a set channel flag is an error
   // the old capture is still unread there, so the new one has no home
   wire  logic [1:0] cap_any  = act_nxt.cap_per | act_nxt.cap_wid
                                | (chan_match_in & capsel);
   wire  logic [1:0] ch_hit   = cap_any | (chan_match_in & ~capsel);
   wire  logic       err_set  = |(cap_any & flags_r[tec_pkg::IRQ_CH +: 2]);
   logic [7:0] flag_set;
   always_comb begin
      flag_set                        = 8'h00;
      flag_set[tec_pkg::IRQ_CH +: 2]  = ch_hit;
      flag_set[tec_pkg::IRQ_SYNC]     = sync_done_in;
      flag_set[tec_pkg::IRQ_ERR]      = err_set;
      flag_set[tec_pkg::IRQ_WRAP]     = wrap_in;
   end
   // set wins over a clear in the same cycle
   wire  logic [7:0] flags_nxt = ((flags_r & ~(wr_flg ? wd0 : 8'h00)) | flag_set)
                                 & tec_pkg::IRQ_MASK;

   // enable state: set view ors in, clear view knocks out ones
   // one register behind both views, so either read shows the same enables
   wire  logic [7:0] irq_en_nxt = wr_set ? (irq_en_r | (wd0 & tec_pkg::IRQ_MASK))
                                : wr_clr ? (irq_en_r & ~wd0)
                                : irq_en_r;

   // ==========================================================
   // bus handshake: waitrequest drops one cycle after the request
   // a fixed single wait state costs a cycle per access, but read data
   // leaves a flop and a write lands only at the edge where the master
   // sees the answer, so nothing is committed twice
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         wait_r  <= 1'b1;
         rdata_r <= 32'h00000000;
      end else begin
         wait_r  <= ~(req & wait_r);
         if (req & wait_r) begin
            rdata_r <= avs_read_in ? rd_mux : 32'h00000000;
         end
      end
   end

   // ==========================================================
   // byte-lane merges for the narrow registers
   // the helper works on 16 bits so one copy serves the debug, capture/invert and event registers; for
   // the debug and capture/invert merges the upper byte is masked off inside and cut away on purpose at the use
   wire  logic [15:0] dbg_mrg    = merge16({8'h00, dbg_r}, avs_writedata_in[15:0],
                                           avs_byteenable_in[1:0],
                                           {8'h00, tec_pkg::DBG_MASK});
   wire  logic [15:0] capinv_mrg = merge16({8'h00, capinv_r}, avs_writedata_in[15:0],
                                           avs_byteenable_in[1:0],
                                           {8'h00, tec_pkg::CAPINV_MASK});

   // ==========================================================
   // debug run bit only on the hard reset
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         dbg_r <= tec_pkg::DBG_RST;
      end else if (wr_dbg) begin
         dbg_r <= dbg_mrg[7:0];
      end
   end

   // ==========================================================
   // control registers, cleared by either reset
   // a software reset clears all of these; only the debug run bit survives it
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         capinv_r <= tec_pkg::CAPINV_RST;
         ev_r     <= tec_pkg::EV_RST;
         irq_en_r <= tec_pkg::IRQ_RST;
         flags_r  <= 8'h00;
      end else if (soft_reset_in) begin
         capinv_r <= tec_pkg::CAPINV_RST;
         ev_r     <= tec_pkg::EV_RST;
         irq_en_r <= tec_pkg::IRQ_RST;
         flags_r  <= 8'h00;
      end else begin
         if (wr_capinv) begin
            capinv_r <= capinv_mrg[7:0];
         end
         if (wr_ev) begin
            ev_r <= merge16(ev_r, avs_writedata_in[15:0],
                            avs_byteenable_in[1:0], tec_pkg::EV_MASK);
         end
         irq_en_r <= irq_en_nxt;
         flags_r  <= flags_nxt;
      end
   end

   // ==========================================================
   // incoming event synchroniser: level moves once stages 2 and 3 agree
   // the first stage may go metastable; only the second reads it, and
   // the agreement test filters a single-cycle glitch on the source
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         ev_sync_r      <= 3'h0;
         ev_lvl_r       <= 1'b0;
         ev_cond_prev_r <= 1'b0;
      end else begin
         ev_sync_r      <= {ev_sync_r[1:0], event_in};
         if (ev_sync_r[1] == ev_sync_r[2]) begin
            ev_lvl_r <= ev_sync_r[2];
         end
         ev_cond_prev_r <= ev_cond;
      end
   end

   // ==========================================================
   // registered outputs
   // every output leaves a flop: one cycle of latency is traded for
   // clean timing at the pins and at the counter core
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         capsel_r <= 2'h0;
         halt_r   <= 1'b0;
         act_r    <= '0;
         wave_r   <= 2'h0;
         chev_r   <= 2'h0;
         wrapev_r <= 1'b0;
         irq_r    <= 1'b0;
      end else begin
         capsel_r <= capsel;
         halt_r   <= debug_halted_in & ~run_dbg;
         act_r    <= act_nxt;
         wave_r   <= wave_raw_in ^ inv;
         chev_r   <= ch_hit & ch_eo;
         wrapev_r <= wrap_in & wrap_eo;
         irq_r    <= |(flags_r & irq_en_r);
      end
   end

   // ==========================================================
   // port drive
   // plain copies of the flops above, no logic between flop and pin
   assign avs_readdata_out           = rdata_r;
   assign avs_waitrequest_out        = wait_r;
   assign channel_capture_select_out = capsel_r;
   assign timer_halt_out             = halt_r;
   assign action_out                 = act_r;
   assign waveform_output_pin_out    = wave_r;
   assign channel_event_out          = chev_r;
   assign wrap_event_out             = wrapev_r;
   assign irq_out                    = irq_r;

endmodule : tec_timer_event_cfg

`default_nettype wire

// >>> core/tec_pkg.sv
// tec_pkg: shared offsets, field positions, reset values and carriers
`default_nettype none
package tec_pkg;

   // ==========================================================
   // register indices (byte address is four times the index)
   localparam logic [5:0] IDX_CAPINV  = 6'h06; // capture select / inversion
   localparam logic [5:0] IDX_DBG     = 6'h08; // debug halt control
   localparam logic [5:0] IDX_EVCFG   = 6'h0A; // event control
   localparam logic [5:0] IDX_IRQCLR  = 6'h0C; // irq enable clear view
   localparam logic [5:0] IDX_IRQSET  = 6'h0D; // irq enable set view
   localparam logic [5:0] IDX_FLAGS   = 6'h0E; // sticky event flags

   // ==========================================================
   // field positions
   localparam int CAPSEL_LSB = 4;  // channel_capture_select[1:0]
   localparam int INV_LSB    = 0;  // channel_output_invert[1:0]
   localparam int EV_CHEO    = 12; // channel_event_output_enable[1:0]
   localparam int EV_WRAPEO  = 8;  // wrap_event_output_enable
   localparam int EV_INEN    = 5;  // input_event_enable
   localparam int EV_INPOL   = 4;  // input_event_polarity
   localparam int IRQ_CH     = 4;  // channel_irq_enable[1:0]
   localparam int IRQ_SYNC   = 3;  // sync_done_irq_enable
   localparam int IRQ_ERR    = 1;  // error irq enable
   localparam int IRQ_WRAP   = 0;  // wrap_irq_enable

   // ==========================================================
   // writable masks and reset values
   localparam logic [7:0]  CAPINV_MASK = 8'h33;
   localparam logic [7:0]  DBG_MASK    = 8'h01;
   localparam logic [15:0] EV_MASK     = 16'h3137;
   localparam logic [7:0]  IRQ_MASK    = 8'h3B;
   localparam logic [7:0]  CAPINV_RST  = 8'h00;
   localparam logic [7:0]  DBG_RST     = 8'h00;
   localparam logic [15:0] EV_RST      = 16'h0000;
   localparam logic [7:0]  IRQ_RST     = 8'h00;

   // ==========================================================
   // event action codes
   localparam logic [2:0] ACT_OFF     = 3'h0;
   localparam logic [2:0] ACT_RETRIG  = 3'h1;
   localparam logic [2:0] ACT_COUNT   = 3'h2;
   localparam logic [2:0] ACT_START   = 3'h3;
   localparam logic [2:0] ACT_PERWID  = 3'h5; // period_first_capture
   localparam logic [2:0] ACT_WIDPER  = 3'h6; // width_first_capture

   // ==========================================================
   // carrier: strobes the block sends to the counter core
   typedef struct packed {
      logic       retrigger; // start / restart / retrigger
      logic       count;     // one count step
      logic       start;     // start counter
      logic [1:0] cap_per;   // capture period into channel n
      logic [1:0] cap_wid;   // capture pulse width into channel n
   } tec_act_s;

endpackage : tec_pkg

`default_nettype wire

// >>> bench/tec_timer_event_cfg_properties.sv
// tec_timer_event_cfg_properties: port-level checks for the config block
`timescale 1ns/1ps
`default_nettype none

module tec_timer_event_cfg_properties (
   // clock, reset, bus
   input wire logic              clk_in,
   input wire logic              nrst_in,
   input wire logic [7:0]        avs_address_in,
   input wire logic              avs_read_in,
   input wire logic              avs_write_in,
   input wire logic [31:0]       avs_readdata_out,
   input wire logic              avs_waitrequest_out,
   // core side and pins
   input wire logic              soft_reset_in,
   input wire logic              debug_halted_in,
   input wire logic [1:0]        chan_match_in,
   input wire logic              wrap_in,
   input wire logic [1:0]        wave_raw_in,
   input wire logic              event_in,
   input wire logic              timer_halt_out,
   input wire tec_pkg::tec_act_s action_out,
   input wire logic [1:0]        waveform_output_pin_out,
   input wire logic [1:0]        channel_event_out,
   input wire logic              wrap_event_out
);
   // ==========
   // helpers
   wire logic [5:0] idx_w   = avs_address_in[7:2]; // register index
   wire logic       quiet_w = !avs_write_in && !soft_reset_in; // config cannot move
   wire logic       map_w   = idx_w inside {6'h06, 6'h08, 6'h0A, 6'h0C, 6'h0D, 6'h0E};

   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   // ==========
   // bus timing: one cycle answer, low for one cycle
   AST_ANSWER: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out) else $error("request not answered in one cycle");
   AST_STAND: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("waitrequest low longer than one cycle");
   AST_UNMAPPED: assert property (avs_read_in && avs_waitrequest_out && !map_w
      |=> avs_readdata_out == 32'h0) else $error("unmapped read not zero");
   // ==========
   // outputs tied to their causes
   AST_HALT: assert property (!debug_halted_in |=> !timer_halt_out)
      else $error("halt without debug halt");
   AST_WRAPEV: assert property (!wrap_in |=> !wrap_event_out)
      else $error("wrap event without wrap");
   AST_CHEV: assert property (chan_match_in == 2'h0
      |=> (channel_event_out & ~(action_out.cap_per | action_out.cap_wid)) == 2'h0)
      else $error("channel event without match or capture");
   AST_WAVE: assert property (quiet_w [*4] |-> (waveform_output_pin_out ^ $past(wave_raw_in))
      == ($past(waveform_output_pin_out) ^ $past(wave_raw_in, 2)))
      else $error("waveform inversion changed without a write");
   AST_ACT_IDLE: assert property ((quiet_w && $stable(event_in)) [*8]
      |-> action_out == '0) else $error("action with no incoming event");
endmodule : tec_timer_event_cfg_properties

bind tec_timer_event_cfg tec_timer_event_cfg_properties u_tec_timer_event_cfg_properties (
   .clk_in, .nrst_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_readdata_out,
   .avs_waitrequest_out, .soft_reset_in, .debug_halted_in, .chan_match_in, .wrap_in,
   .wave_raw_in, .event_in, .timer_halt_out, .action_out, .waveform_output_pin_out,
   .channel_event_out, .wrap_event_out);
`default_nettype wire

// >>> bench/tec_evsys_model.sv
// tec_evsys_model: event routing partner, one high-then-low pulse per go
`timescale 1ns/1ps
`default_nettype none

module tec_evsys_model (
   // clock and trigger
   input  wire logic clk_in,
   input  wire logic go_in,
   // event level toward the block
   output logic      event_out
);
   // ==========
   // pulse shaper: six cycles high, then six low
   logic [4:0] cnt_r = 5'h00; // cycles left in the pulse
   always_ff @(posedge clk_in) begin
      if (go_in) begin
         cnt_r <= 5'h0C;
      end else if (cnt_r != 5'h00) begin
         cnt_r <= cnt_r - 5'h01;
      end
   end
   // plain level; the block resynchronises it
   assign event_out = (cnt_r > 5'h06);
endmodule : tec_evsys_model
`default_nettype wire

// >>> bench/tb_timer_event_capture_config.sv
// tb_timer_event_capture_config: self-checking bench for the config block
`timescale 1ns/1ps
`default_nettype none

module tb_timer_event_capture_config;
   // ==========
   // stimulus and observed signals
   logic              clk_in = 1'b0;
   logic              nrst_in = 1'b0;
   logic [7:0]        addr = 8'h00;
   logic              rd_en = 1'b0;
   logic              wr_en = 1'b0;
   logic [31:0]       wdata = 32'h0;
   logic              sreset = 1'b0;
   logic              dbg_halt = 1'b0;
   logic [1:0]        match = 2'h0;
   logic              wrap = 1'b0;
   logic              sync = 1'b0;
   logic [1:0]        raw = 2'h0;
   logic              go = 1'b0;
   wire logic         ev_w;
   logic [31:0]       rdata, v, q;
   logic [1:0]        capsel_o, wave_o, chev_o;
   logic              wait_o, halt_o, wrapev_o, irq_o;
   tec_pkg::tec_act_s act_o;
   logic [6:0]        first;
   int                fail_count = 0;
   int                comparisons = 0;
   integer            seed = 32'h0000BE90; // fixed seed, repeatable run

   initial begin
      forever #12.5 clk_in = ~clk_in;
   end

   tec_evsys_model u_tec_evsys_model (.clk_in(clk_in), .go_in(go), .event_out(ev_w));

   tec_timer_event_cfg u_tec_timer_event_cfg (
      .clk_in(clk_in), .nrst_in(nrst_in), .avs_address_in(addr), .avs_read_in(rd_en),
      .avs_write_in(wr_en), .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
      .avs_readdata_out(rdata), .avs_waitrequest_out(wait_o), .soft_reset_in(sreset),
      .debug_halted_in(dbg_halt), .chan_match_in(match), .wrap_in(wrap),
      .sync_done_in(sync), .wave_raw_in(raw), .event_in(ev_w),
      .channel_capture_select_out(capsel_o), .timer_halt_out(halt_o), .action_out(act_o),
      .waveform_output_pin_out(wave_o), .channel_event_out(chev_o),
      .wrap_event_out(wrapev_o), .irq_out(irq_o));

   // ==========
   // helpers: bus cycle, compare, expectations
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      wr_en <= w;
      rd_en <= !w;
      // hold until waitrequest is seen low; only the watchdog ends a hang
      do begin
         @(posedge clk_in);
      end while (wait_o !== 1'b0);
      q = rdata;
      wr_en <= 1'b0;
      rd_en <= 1'b0;
   endtask : bus

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask : rd

   // one match/capture and wrap strobe, outputs settle one cycle later
   task automatic pulse(input logic [1:0] m);
      match <= m;
      wrap <= 1'b1;
      @(posedge clk_in);
      match <= 2'h0;
      wrap <= 1'b0;
      @(posedge clk_in);
   endtask : pulse

   // first strobe expected for each event-action case
   function automatic logic [6:0] exp_act(input int i);
      case (i)
         1: return 7'h40;
         2: return 7'h20;
         3: return 7'h10;
         5: return 7'h04;
         6: return 7'h08;
         8: return 7'h02;
         9: return 7'h01;
         default: return 7'h00;
      endcase
   endfunction : exp_act

   task automatic end_of_test();
      if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : end_of_test

   // watchdog, far beyond the expected run
   initial begin
      repeat (20000) @(posedge clk_in);
      fail_count++;
      end_of_test();
   end

   // ==========
   // main sequence
   initial begin
      repeat (10) @(posedge clk_in);
      nrst_in <= 1'b1;
      for (int k = 0; k < 4; k++) rd(8'h18 + 8'(8 * k), 32'h0);
      rd(8'h3C, 32'h0);
      for (int k = 0; k < 6; k++) begin
         v = $random(seed);
         bus(1'b1, 8'h18, v);
         bus(1'b1, 8'h20, v >> 8);
         bus(1'b1, 8'h28, v);
         rd(8'h18, v & 32'h33);
         rd(8'h20, (v >> 8) & 32'h1);
         rd(8'h28, v & 32'h3137);
         raw <= v[17:16];
         dbg_halt <= v[18];
         repeat (2) @(posedge clk_in);
         chk(32'(wave_o), 32'(v[17:16] ^ v[1:0]));
         chk(32'(capsel_o), 32'(v[5:4]));
         chk(32'(halt_o), 32'(v[18] & ~v[8]));
      end
      bus(1'b1, 8'h28, 32'h3100);
      pulse(v[1:0]);
      chk(32'({chev_o, wrapev_o}), 32'({v[1:0], 1'b1}));
      bus(1'b1, 8'h28, 32'h0);
      pulse(2'h3);
      chk(32'({chev_o, wrapev_o}), 32'h0);
      for (int i = 0; i < 11; i++) begin
         bus(1'b1, 8'h28, (i < 8) ? 32'h20 + i : (i == 8 ? 32'h35 : (i == 9 ? 32'h36 : 32'h2)));
         repeat (12) @(posedge clk_in);
         go <= 1'b1;
         @(posedge clk_in);
         go <= 1'b0;
         first = 7'h00;
         repeat (30) begin
            @(posedge clk_in);
            if (first == 7'h00) first = act_o;
         end
         chk(32'(first), 32'(exp_act(i)));
      end
      bus(1'b1, 8'h20, 32'h1);
      sreset <= 1'b1;
      @(posedge clk_in);
      sreset <= 1'b0;
      rd(8'h20, 32'h1);
      rd(8'h18, 32'h0);
      bus(1'b1, 8'h34, 32'hFF);
      bus(1'b1, 8'h30, 32'h11);
      rd(8'h34, 32'h2A);
      bus(1'b1, 8'h30, 32'h08);
      bus(1'b1, 8'h30, 32'h00);
      rd(8'h30, 32'h22);
      bus(1'b1, 8'h18, 32'h10);
      pulse(2'h1);
      pulse(2'h1);
      rd(8'h38, 32'h13);
      chk(32'(irq_o), 32'h1);
      bus(1'b1, 8'h30, 32'h02);
      repeat (2) @(posedge clk_in);
      chk(32'(irq_o), 32'h0);
      sync <= 1'b1;
      @(posedge clk_in);
      sync <= 1'b0;
      repeat (3) @(posedge clk_in);
      chk(32'(irq_o), 32'h0);
      bus(1'b1, 8'h34, 32'h08);
      repeat (2) @(posedge clk_in);
      chk(32'(irq_o), 32'h1);
      bus(1'b1, 8'h30, 32'h08);
      repeat (2) @(posedge clk_in);
      chk(32'(irq_o), 32'h0);
      end_of_test();
   end
endmodule : tb_timer_event_capture_config
`default_nettype wire
